// >>> pkg/tra_pkg.sv
// Constants, register map and shared helpers for the tile row-add and scaled-add datapath.
package tra_pkg;
  // Streaming vector length and derived geometry.
  localparam int VL_BITS = 128;
  localparam int PL_BITS = VL_BITS / 8;
  localparam int ARR_ROWS = VL_BITS / 8;
  localparam int ROW_STEPS = VL_BITS / 32;
  localparam logic [63:0] PRED_BYTES = 64'(VL_BITS / 64);
  localparam logic [63:0] VEC_BYTES = 64'(VL_BITS / 8);
  // Feature presence; the values are implementation choices.
  localparam logic MATRIX_IMPL = 1'b1;
  localparam logic WIDE_PRESENT = 1'b1;
  // Register byte addresses.
  localparam int ADR_W = 8;
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_CMD = 8'h04;
  localparam logic [7:0] ADR_STATUS = 8'h08;
  localparam logic [7:0] ADR_FEATURE = 8'h0C;
  localparam logic [7:0] ADR_ROWIDX = 8'h10;
  localparam logic [7:0] ADR_ROW_BASE = 8'h20;
  localparam logic [7:0] ADR_VEC_BASE = 8'h30;
  localparam logic [7:0] ADR_PRED_BASE = 8'h40;
  localparam logic [7:0] ADR_SCALAR_LO = 8'h60;
  localparam logic [7:0] ADR_SCALAR_HI = 8'h64;
  localparam logic [7:0] ADR_SP_LO = 8'h68;
  localparam logic [7:0] ADR_SP_HI = 8'h6C;
  localparam logic [7:0] ADR_RES_LO = 8'h70;
  localparam logic [7:0] ADR_RES_HI = 8'h74;
  // Control bits.
  localparam int CTRL_MATRIX_EN = 0;
  localparam int CTRL_STREAM_EN = 1;
  localparam int CTRL_TILE_EN = 2;
  localparam int CTRL_DIT = 3;
  localparam logic [3:0] CTRL_RST = 4'h0;
  // Command fields.
  localparam int CMD_OP = 0;
  localparam int CMD_WIDE = 2;
  localparam int CMD_TILE = 3;
  localparam int CMD_PFIRST = 6;
  localparam int CMD_PSECOND = 9;
  localparam int CMD_SRC = 12;
  localparam int CMD_DST = 17;
  localparam int CMD_IMM = 22;
  localparam logic [31:0] CMD_RST = 32'h0;
  localparam logic [1:0] OP_TILE_ROW_ADD = 2'h0;
  localparam logic [1:0] OP_PRED_SIZE_ADD = 2'h1;
  localparam logic [1:0] OP_VEC_SIZE_ADD = 2'h2;
  localparam logic [4:0] SP_REGNUM = 5'h1F;
  // Status bits.
  localparam int ST_BUSY = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_UNDEF = 2;
  localparam int ST_TRAP = 3;

  // Predicate bit governing element idx at 32-bit or 64-bit element size.
  function automatic logic predBit(input logic [PL_BITS-1:0] p, input int idx, input logic wide);
    predBit = wide ? p[(idx * 8) % PL_BITS] : p[(idx * 4) % PL_BITS];
  endfunction : predBit
endpackage : tra_pkg

// >>> design/tra_row_lane.sv
// One accumulator row: masked element-wise add of the source vector.
`timescale 1ns/1ns
module tra_row_lane
  import tra_pkg::*;
(
  input wire logic [tra_pkg::VL_BITS-1:0] rowIn,
  input wire logic [tra_pkg::VL_BITS-1:0] srcVec,
  input wire logic [tra_pkg::PL_BITS-1:0] colMask,
  input wire logic rowActive,
  input wire logic wide,
  output logic [tra_pkg::VL_BITS-1:0] rowOut
);
  // Column j takes source element j; carries stay inside the element.
  always_comb
  begin
    rowOut = rowIn;
    if (wide)
    begin
      for (int j = 0; j < VL_BITS / 64; j++)
        if (rowActive && predBit(colMask, j, 1'b1)) // see RULE8
          rowOut[64*j+:64] = rowIn[64*j+:64] + srcVec[64*j+:64]; // see RULE19
    end
    else
    begin
      for (int j = 0; j < VL_BITS / 32; j++)
        if (rowActive && predBit(colMask, j, 1'b0)) // see RULE2
          rowOut[32*j+:32] = rowIn[32*j+:32] + srcVec[32*j+:32]; // see RULE19
    end
  end
endmodule : tra_row_lane

// >>> design/tra_tile_row_add.sv
// Tile row-add and scaled-add execution unit with a classic Wishbone register slave.
// Operation
// RULE1: Add source vector to active elements of every tile row, write back.
// RULE2: Element active when column bit of second and row bit of first predicate set.
// RULE3: Inactive tile elements keep their contents.
// RULE4: Narrow form selects one of four tiles, wide form one of eight.
// RULE5: Wide form optional; a feature bit reports it, absent means undefined.
// RULE6: Both predicates come from the first eight predicate registers.
// RULE7: Tile dimension is vector length over element size, rows and columns.
// RULE8: Source element at a column index adds to that column in every row.
// RULE9: All three operations undefined when the matrix feature is absent.
// RULE10: With timing flag set, latency ignores data and condition flags.
// RULE11: With timing flag set, exception response ignores data values.
// RULE12: Predicate-size add uses immediate times vector bits over 64.
// RULE13: Scaled adds take a six-bit signed immediate, -32 to 31.
// RULE14: Scalar register number 31 selects the stack pointer.
// RULE15: Scaled adds run whether or not streaming mode is on.
// RULE16: Vector-size add adds immediate times vector bytes, 64-bit result.
// RULE17: Vector-size add uses immediate times vector bits over 8.
// RULE18: Tile add needs streaming and tile enables; scaled adds the matrix enable.
// RULE19: Element sums wrap at element width, carry discarded.
//
// Implementation choices: register access over Wishbone and the address map.
`timescale 1ns/1ns
module tra_tile_row_add
  import tra_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [tra_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  typedef enum logic [1:0] {S_IDLE, S_ROWS, S_DONE} tra_state_t;

  tra_state_t state, next_state;
  logic [1:0] step, next_step;
  logic [3:0] ctrl, next_ctrl;
  logic [31:0] cmd, next_cmd;
  logic doneFlag, next_doneFlag;
  logic undefFlag, next_undefFlag;
  logic trapFlag, next_trapFlag;
  logic [3:0] rowIdx, next_rowIdx;
  logic [VL_BITS-1:0] srcVec, next_srcVec;
  logic [PL_BITS-1:0] pred [8];
  logic [PL_BITS-1:0] next_pred [8];
  logic [63:0] scalarSrc, next_scalarSrc;
  logic [63:0] stackPtr, next_stackPtr;
  logic [63:0] result, next_result;
  logic [VL_BITS-1:0] tileArr [ARR_ROWS];
  logic [VL_BITS-1:0] next_tileArr [ARR_ROWS];
  logic [31:0] next_datO;
  logic next_ack;

  logic reqNew;
  logic busWr;
  logic start;
  logic [1:0] newOp;
  logic newWide;
  logic isUndef;
  logic isTrap;
  logic wideCmd;
  logic [3:0] curRow;
  logic rowActive;
  logic [VL_BITS-1:0] rowSum;
  logic [63:0] scalarIn;
  logic [63:0] scaledVal;

  // Merges a byte-lane write into an existing word.
  function automatic logic [31:0] mergeSel(input logic [31:0] old, input logic [31:0] wdat, input logic [3:0] sel);
    for (int b = 0; b < 4; b++)
      mergeSel[8*b+:8] = sel[b] ? wdat[8*b+:8] : old[8*b+:8];
  endfunction : mergeSel

  // Sign-extends the six-bit immediate and scales it by a byte count, wrapping at 64 bits.
  function automatic logic [63:0] scaledAdd(input logic [63:0] opnd, input logic [5:0] imm, input logic [63:0] bytes);
    logic [63:0] immExt;
    immExt = {{58{imm[5]}}, imm}; // see RULE13
    scaledAdd = opnd + 64'(immExt * bytes);
  endfunction : scaledAdd

  // Command decode: fields of the word being written, checked before it starts.
  always_comb
  begin
    reqNew = wb_cyc_i && wb_stb_i && !wb_ack_o;
    busWr = reqNew && wb_we_i;
    start = busWr && (wb_adr_i == ADR_CMD) && (state == S_IDLE);
    newOp = wb_dat_i[CMD_OP+:2];
    newWide = wb_dat_i[CMD_WIDE];
    isUndef = !MATRIX_IMPL || (newOp == 2'h3) // see RULE9
      || ((newOp == OP_TILE_ROW_ADD) && newWide && !WIDE_PRESENT); // see RULE5
    if (newOp == OP_TILE_ROW_ADD)
      isTrap = !(ctrl[CTRL_STREAM_EN] && ctrl[CTRL_TILE_EN]); // see RULE18
    else
      isTrap = !ctrl[CTRL_MATRIX_EN]; // see RULE15
  end

  // Row being worked: tile rows interleave through the array at a stride of the tile count (4 narrow, 8 wide).
  always_comb
  begin
    wideCmd = cmd[CMD_WIDE];
    if (wideCmd)
      curRow = {step[0], cmd[CMD_TILE+:3]}; // see RULE4
    else
      curRow = {step, cmd[CMD_TILE+:2]}; // see RULE4
    // In the wide form only two steps are real rows; the others idle so latency stays fixed.
    rowActive = predBit(pred[cmd[CMD_PFIRST+:3]], int'(step), wideCmd) // see RULE6
      && (!wideCmd || !step[1]); // see RULE7
    scalarIn = (wb_dat_i[CMD_SRC+:5] == SP_REGNUM) ? stackPtr : scalarSrc; // see RULE14
    if (newOp == OP_PRED_SIZE_ADD)
      scaledVal = scaledAdd(scalarIn, wb_dat_i[CMD_IMM+:6], PRED_BYTES); // see RULE12
    else
      scaledVal = scaledAdd(scalarIn, wb_dat_i[CMD_IMM+:6], VEC_BYTES); // see RULE16
  end

  tra_row_lane u_lane (
    .rowIn(tileArr[curRow]),
    .srcVec(srcVec),
    .colMask(pred[cmd[CMD_PSECOND+:3]]),
    .rowActive(rowActive),
    .wide(wideCmd),
    .rowOut(rowSum)
  );

  // Register file, bus answer and sequencer next values.
  always_comb
  begin
    next_state = state;
    next_step = step;
    next_ctrl = ctrl;
    next_cmd = cmd;
    next_doneFlag = doneFlag;
    next_undefFlag = undefFlag;
    next_trapFlag = trapFlag;
    next_rowIdx = rowIdx;
    next_srcVec = srcVec;
    next_pred = pred;
    next_scalarSrc = scalarSrc;
    next_stackPtr = stackPtr;
    next_result = result;
    next_tileArr = tileArr;
    next_ack = reqNew;
    next_datO = 32'h0;
    // Read data is captured with the request so it stands beside ack.
    if (reqNew && !wb_we_i)
    begin
      if (wb_adr_i[7:4] == ADR_ROW_BASE[7:4])
        next_datO = tileArr[rowIdx][32*wb_adr_i[3:2]+:32];
      else if (wb_adr_i[7:4] == ADR_VEC_BASE[7:4])
        next_datO = srcVec[32*wb_adr_i[3:2]+:32];
      else if (wb_adr_i[7:5] == ADR_PRED_BASE[7:5])
        next_datO = 32'(pred[wb_adr_i[4:2]]);
      else
        unique case (wb_adr_i)
          ADR_CTRL: next_datO = 32'(ctrl);
          ADR_CMD: next_datO = cmd;
          ADR_STATUS: next_datO = 32'({trapFlag, undefFlag, doneFlag, state != S_IDLE});
          ADR_FEATURE: next_datO = 32'({WIDE_PRESENT, MATRIX_IMPL}); // see RULE5
          ADR_ROWIDX: next_datO = 32'(rowIdx);
          ADR_SCALAR_LO: next_datO = scalarSrc[31:0];
          ADR_SCALAR_HI: next_datO = scalarSrc[63:32];
          ADR_SP_LO: next_datO = stackPtr[31:0];
          ADR_SP_HI: next_datO = stackPtr[63:32];
          ADR_RES_LO: next_datO = result[31:0];
          ADR_RES_HI: next_datO = result[63:32];
          default: next_datO = 32'h0;
        endcase
    end
    // Operand writes are dropped while busy so the running operation sees stable inputs.
    if (busWr && (state == S_IDLE))
    begin
      if (wb_adr_i[7:4] == ADR_ROW_BASE[7:4])
        next_tileArr[rowIdx][32*wb_adr_i[3:2]+:32] =
          mergeSel(tileArr[rowIdx][32*wb_adr_i[3:2]+:32], wb_dat_i, wb_sel_i);
      else if (wb_adr_i[7:4] == ADR_VEC_BASE[7:4])
        next_srcVec[32*wb_adr_i[3:2]+:32] = mergeSel(srcVec[32*wb_adr_i[3:2]+:32], wb_dat_i, wb_sel_i);
      else if (wb_adr_i[7:5] == ADR_PRED_BASE[7:5])
        next_pred[wb_adr_i[4:2]] = PL_BITS'(mergeSel(32'(pred[wb_adr_i[4:2]]), wb_dat_i, wb_sel_i));
      else
        unique case (wb_adr_i)
          ADR_CTRL: next_ctrl = 4'(mergeSel(32'(ctrl), wb_dat_i, wb_sel_i));
          ADR_ROWIDX: next_rowIdx = 4'(mergeSel(32'(rowIdx), wb_dat_i, wb_sel_i));
          ADR_SCALAR_LO: next_scalarSrc[31:0] = mergeSel(scalarSrc[31:0], wb_dat_i, wb_sel_i);
          ADR_SCALAR_HI: next_scalarSrc[63:32] = mergeSel(scalarSrc[63:32], wb_dat_i, wb_sel_i);
          ADR_SP_LO: next_stackPtr[31:0] = mergeSel(stackPtr[31:0], wb_dat_i, wb_sel_i);
          ADR_SP_HI: next_stackPtr[63:32] = mergeSel(stackPtr[63:32], wb_dat_i, wb_sel_i);
          default: next_step = step;
        endcase
    end
    // Status flags clear by writing one; a set in the same cycle wins below.
    if (busWr && (wb_adr_i == ADR_STATUS))
    begin
      if (wb_dat_i[ST_DONE_BIT])
        next_doneFlag = 1'b0;
      if (wb_dat_i[ST_UNDEF])
        next_undefFlag = 1'b0;
      if (wb_dat_i[ST_TRAP])
        next_trapFlag = 1'b0;
    end
    // Sequencer: every command ends in S_DONE; a tile add that neither traps nor is undefined walks all steps.
    unique case (state)
      S_IDLE:
        if (start)
        begin
          next_cmd = wb_dat_i;
          next_step = 2'h0;
          next_state = S_DONE;
          if (isUndef)
            next_undefFlag = 1'b1; // see RULE9
          else if (isTrap)
            next_trapFlag = 1'b1; // see RULE18
          else if (newOp == OP_TILE_ROW_ADD)
            next_state = S_ROWS;
          else if (wb_dat_i[CMD_DST+:5] == SP_REGNUM)
            next_stackPtr = scaledVal; // see RULE14
          else
            next_result = scaledVal; // see RULE17
        end
      S_ROWS:
      begin
        // No abort path: traps and undefined encodings are flagged at start, so the walk always runs to the fixed end, whatever the data.
        next_tileArr[curRow] = rowSum; // see RULE1
        next_step = step + 2'h1;
        if (step == 2'(ROW_STEPS - 1))
          next_state = S_DONE; // see RULE10
      end
      S_DONE:
      begin
        next_doneFlag = 1'b1; // see RULE11
        next_state = S_IDLE;
      end
    endcase
  end

  // State registers; the clock enable freezes everything except reset, which acts even with the enable low.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state <= S_IDLE;
      step <= 2'h0;
      ctrl <= CTRL_RST;
      cmd <= CMD_RST;
      doneFlag <= 1'b0;
      undefFlag <= 1'b0;
      trapFlag <= 1'b0;
      rowIdx <= 4'h0;
      srcVec <= '0;
      pred <= '{default: '0};
      scalarSrc <= 64'h0;
      stackPtr <= 64'h0;
      result <= 64'h0;
      tileArr <= '{default: '0};
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else if (ce)
    begin
      state <= next_state;
      step <= next_step;
      ctrl <= next_ctrl;
      cmd <= next_cmd;
      doneFlag <= next_doneFlag;
      undefFlag <= next_undefFlag;
      trapFlag <= next_trapFlag;
      rowIdx <= next_rowIdx;
      srcVec <= next_srcVec;
      pred <= next_pred;
      scalarSrc <= next_scalarSrc;
      stackPtr <= next_stackPtr;
      result <= next_result;
      tileArr <= next_tileArr;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_datO;
    end
  end

  // Checks assume the clock enable stays high across each checked window.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn || !ce);

  sequence seqTileStart;
    start && !isUndef && !isTrap && (newOp == OP_TILE_ROW_ADD);
  endsequence
  sequence seqRowsThenDone;
    (state == S_ROWS) [*4] ##1 (state == S_DONE) ##1 doneFlag;
  endsequence

  AST_ACK_ONE: assert property (reqNew |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle after request");
  AST_TILE_LATENCY: assert property (seqTileStart |=> seqRowsThenDone) // see RULE10
    else $error("tile add latency not fixed");
  AST_INACTIVE_KEPT: assert property ((state == S_ROWS) && !rowActive // see RULE3
    |=> tileArr[$past(curRow)] == $past(tileArr[curRow]))
    else $error("inactive row changed");
  AST_ELEM_ADD: assert property ((state == S_ROWS) && rowActive && !wideCmd // see RULE19
    && predBit(pred[cmd[CMD_PSECOND+:3]], 0, 1'b0)
    |-> rowSum[31:0] == tileArr[curRow][31:0] + srcVec[31:0])
    else $error("element sum wrong");
  AST_UNDEF_NOFEAT: assert property (start && (!MATRIX_IMPL || (newOp == 2'h3)) // see RULE9
    |=> undefFlag && (state == S_DONE))
    else $error("undefined encoding not flagged");
  AST_TILE_TRAP: assert property (start && !isUndef && (newOp == OP_TILE_ROW_ADD) // see RULE18
    && (!ctrl[CTRL_STREAM_EN] || !ctrl[CTRL_TILE_EN]) |=> trapFlag && (state == S_DONE))
    else $error("tile add ran without streaming and tile enables");
  AST_PSIZE_RES: assert property (start && !isUndef && !isTrap && (newOp == OP_PRED_SIZE_ADD) // see RULE12
    && (wb_dat_i[CMD_DST+:5] != SP_REGNUM)
    |=> result == $past(scalarIn) + 64'($signed($past(wb_dat_i[CMD_IMM+:6])) * $signed(PRED_BYTES)))
    else $error("predicate-size add result wrong");
  AST_SP_DEST: assert property (start && !isUndef && !isTrap && (newOp != OP_TILE_ROW_ADD) // see RULE14
    && (wb_dat_i[CMD_DST+:5] == SP_REGNUM) |=> $stable(result) && stackPtr == $past(scaledVal))
    else $error("stack pointer destination not honoured");
  AST_NO_STREAM_NEEDED: assert property (start && !isUndef && (newOp != OP_TILE_ROW_ADD) // see RULE15
    && ctrl[CTRL_MATRIX_EN] |=> !trapFlag)
    else $error("scaled add trapped outside streaming mode");
endmodule : tra_tile_row_add

// >>> verif/tra_host_model.sv
// Behavioural bus master standing in for the processor side of the register slave.
`timescale 1ns/1ns
module tra_host_model
  import tra_pkg::*;
(
  input wire logic clk,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  output logic wb_cyc_i,
  output logic wb_stb_i,
  output logic wb_we_i,
  output logic [tra_pkg::ADR_W-1:0] wb_adr_i,
  output logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_i
);
  import tra_pkg::*;

  // The bus idles low at time zero.
  initial
  begin
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
  end

  // One classic cycle, held until ack is sampled high at an edge.
  // Write data is inverted on release so a stale bus value is never trusted.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    @(posedge clk);
    while (wb_ack_o !== 1'b1)
      @(posedge clk);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    wb_dat_i <= ~d;
  endtask : xfer
endmodule : tra_host_model

// >>> verif/tra_tile_row_add_tb_top.sv
// Self-checking bench for the tile row-add and scaled-add unit.
`timescale 1ns/1ns
module tra_tile_row_add_tb_top;
  import tra_pkg::*;
  logic clk;
  logic rstn;
  logic ce;
  logic cyc, stb, we, ack;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] datW, datR;
  int numErrors = 0;
  int checkCount = 0;
  logic [31:0] arr [16][4];
  logic [31:0] vec [4];
  logic [31:0] st;
  logic [63:0] e;
  int p1, p2;

  tra_tile_row_add u_dut (.clk(clk), .rstn(rstn), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(datR), .wb_ack_o(ack));
  tra_host_model u_host (.clk(clk), .wb_ack_o(ack), .wb_dat_o(datR), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW));

  // Free-running 125 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    u_host.xfer(1'b1, a, d, q);
  endtask : wr

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checkCount++;
    if (got !== exp)
    begin
      numErrors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input string msg);
    logic [31:0] q;
    u_host.xfer(1'b0, a, 32'h0, q);
    chk(q, exp, msg);
  endtask : rdChk

  // Polls until done, counting polls so latency can be compared, then clears the flags.
  task automatic waitDone(output logic [31:0] s, output int polls);
    polls = 0;
    s = 32'h0;
    while (s[ST_DONE_BIT] !== 1'b1)
    begin
      u_host.xfer(1'b0, ADR_STATUS, 32'h0, s);
      polls++;
    end
    wr(ADR_STATUS, 32'h0000_000E);
  endtask : waitDone

  function automatic logic [31:0] cmd(input logic [1:0] op, input logic wd, input logic [2:0] t,
    input logic [2:0] pf, input logic [2:0] ps, input logic [4:0] src, input logic [4:0] dst, input logic [5:0] imm);
    cmd = {4'h0, imm, dst, src, ps, pf, t, wd, op};
  endfunction : cmd

  // Loads the array, vector and predicates, runs one tile add and checks every array word.
  // Unused predicates are all ones, so a wrong predicate selection enables extra elements.
  task automatic tileRun(input logic wd, input logic [2:0] t, input logic [2:0] pf, input logic [2:0] ps,
    input logic [15:0] pa, input logic [15:0] pb, input logic [31:0] base, output int polls);
    logic [31:0] s;
    logic [63:0] x;
    logic act;
    int r, c;
    for (int k = 0; k < 16; k++)
    begin
      wr(ADR_ROWIDX, 32'(k));
      for (int w = 0; w < 4; w++)
      begin
        arr[k][w] = base | 32'(k * 16 + w);
        wr(ADR_ROW_BASE + 8'(4 * w), arr[k][w]);
      end
    end
    for (int w = 0; w < 4; w++)
    begin
      vec[w] = 32'h0000_0200 + 32'(w);
      wr(ADR_VEC_BASE + 8'(4 * w), vec[w]);
    end
    for (int p = 0; p < 8; p++)
      wr(ADR_PRED_BASE + 8'(4 * p), (p == pf) ? {16'h0, pa} : (p == ps) ? {16'h0, pb} : 32'h0000_FFFF);
    wr(ADR_CMD, cmd(OP_TILE_ROW_ADD, wd, t, pf, ps, 5'h00, 5'h00, 6'h00));
    waitDone(s, polls);
    chk(s & 32'h0000_000C, 32'h0, "tile flags");
    for (int k = 0; k < 16; k++)
    begin
      wr(ADR_ROWIDX, 32'(k));
      for (int w = 0; w < 4; w++)
      begin
        r = wd ? k / 8 : k / 4;
        c = wd ? w / 2 : w;
        act = (wd ? (k % 8 == t) : (k % 4 == t[1:0])) && pa[(wd ? 8 : 4) * r] && pb[(wd ? 8 : 4) * c];
        if (wd)
          x = {arr[k][2 * c + 1], arr[k][2 * c]} + (act ? {vec[2 * c + 1], vec[2 * c]} : 64'h0);
        else
          x = {32'h0, arr[k][w] + (act ? vec[w] : 32'h0)};
        if (wd && w % 2 == 1)
          x = x >> 32;
        rdChk(ADR_ROW_BASE + 8'(4 * w), x[31:0], "tile");
      end
    end
  endtask : tileRun

  task automatic completeRun();
    $display("checks %0d errors %0d", checkCount, numErrors);
    if (numErrors == 0 && checkCount > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : completeRun

  // Cuts a hang short well beyond the expected run length.
  initial
  begin
    repeat (80000) @(posedge clk);
    numErrors++;
    completeRun();
  end

  // Main sequence.
  initial
  begin
    rstn = 1'b0;
    ce = 1'b1;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rdChk(ADR_FEATURE, 32'h0000_0003, "feature");
    rdChk(ADR_CTRL, 32'h0, "ctrl reset");
    rdChk(8'h80, 32'h0, "unmapped");
    wr(ADR_CTRL, 32'h0000_000F);
    // Narrow form with tile field bit 2 set: only the low two bits pick the tile.
    tileRun(1'b0, 3'h5, 3'h2, 3'h5, 16'h0101, 16'h1110, 32'hFFFF_FF00, p1);
    tileRun(1'b0, 3'h5, 3'h2, 3'h5, 16'h0101, 16'h1110, 32'h1234_5600, p2);
    chk(32'(p1), 32'(p2), "latency");
    // No streaming enable: the tile add traps and all-ones predicates change nothing.
    wr(ADR_CTRL, 32'h0000_0005);
    wr(ADR_CMD, cmd(OP_TILE_ROW_ADD, 1'b0, 3'h0, 3'h0, 3'h1, 5'h00, 5'h00, 6'h00));
    waitDone(st, p1);
    chk(st & 32'h0000_000C, 32'h0000_0008, "tile trap");
    wr(ADR_ROWIDX, 32'h0);
    rdChk(ADR_ROW_BASE, arr[0][0], "trap keeps array");
    wr(ADR_CTRL, 32'h0000_000F);
    tileRun(1'b1, 3'h5, 3'h0, 3'h7, 16'h0100, 16'h0001, 32'hFFFF_FF00, p1);
    // Scaled adds with streaming off.
    wr(ADR_CTRL, 32'h0000_0001);
    wr(ADR_SCALAR_LO, 32'h0000_0010);
    wr(ADR_SCALAR_HI, 32'h0000_0001);
    wr(ADR_SP_LO, 32'h0000_0010);
    wr(ADR_SP_HI, 32'h0);
    wr(ADR_CMD, cmd(OP_PRED_SIZE_ADD, 1'b0, 3'h0, 3'h0, 3'h0, 5'h03, 5'h04, 6'h20));
    waitDone(st, p1);
    chk(st & 32'h0000_000C, 32'h0, "scaled flags");
    e = 64'h0000_0001_0000_0010 + 64'(-32 * (VL_BITS / 64));
    rdChk(ADR_RES_LO, e[31:0], "pred add lo");
    rdChk(ADR_RES_HI, e[63:32], "pred add hi");
    wr(ADR_CMD, cmd(OP_VEC_SIZE_ADD, 1'b0, 3'h0, 3'h0, 3'h0, 5'h1F, 5'h1F, 6'h1F));
    waitDone(st, p1);
    e = 64'h10 + 64'(31 * (VL_BITS / 8));
    rdChk(ADR_SP_LO, e[31:0], "vec add sp lo");
    rdChk(ADR_SP_HI, e[63:32], "vec add sp hi");
    wr(ADR_CMD, cmd(OP_VEC_SIZE_ADD, 1'b0, 3'h0, 3'h0, 3'h0, 5'h1F, 5'h02, 6'h3F));
    waitDone(st, p1);
    e = e + 64'(-1 * (VL_BITS / 8));
    rdChk(ADR_RES_LO, e[31:0], "vec add neg lo");
    rdChk(ADR_RES_HI, e[63:32], "vec add neg hi");
    wr(ADR_CTRL, 32'h0);
    wr(ADR_CMD, cmd(OP_PRED_SIZE_ADD, 1'b0, 3'h0, 3'h0, 3'h0, 5'h03, 5'h04, 6'h01));
    waitDone(st, p1);
    chk(st & 32'h0000_000C, 32'h0000_0008, "scaled trap");
    wr(ADR_CTRL, 32'h0000_000F);
    wr(ADR_CMD, 32'h0000_0003);
    waitDone(st, p1);
    chk(st & 32'h0000_000C, 32'h0000_0004, "undefined op");
    completeRun();
  end
endmodule : tra_tile_row_add_tb_top
